// ---- crt_pkg.sv ----
/*
  constants for the cascadable reload timer: register indices, field
  positions, reset values, mode encodings and the slow-rate divider.
  assumes nothing of its surroundings; every user writes crt_pkg::name.
*/
`default_nettype none

package crt_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register indices; byte address on the bus is four times the index
  localparam logic [5:0] IDX_CONTROL     = 6'h19;
  localparam logic [5:0] IDX_RELOAD_HIGH = 6'h1A;
  localparam logic [5:0] IDX_RELOAD_LOW  = 6'h1B;
  localparam logic [5:0] IDX_COUNT_HIGH  = 6'h1C;
  localparam logic [5:0] IDX_COUNT_LOW   = 6'h1D;
  localparam logic [5:0] IDX_IRQ_STATUS  = 6'h30;
  localparam logic [5:0] IDX_IRQ_MASK    = 6'h31;
  localparam logic [5:0] IDX_COMMAND     = 6'h32;

  ////////////////////////////////////////////////////////////////////////////
  // control register fields
  localparam int unsigned CTL_STOP_RX_BIT  = 7;
  localparam int unsigned CTL_START_HI     = 5;
  localparam int unsigned CTL_START_LO     = 4;
  localparam int unsigned CTL_AUTO_BIT     = 3;
  localparam int unsigned CTL_CLK_HI       = 1;
  localparam int unsigned CTL_CLK_LO       = 0;
  localparam logic [7:0]  CTL_WRITE_MASK   = 8'hBB;

  // interrupt status / mask fields
  localparam int unsigned IRQ_UNDERFLOW_BIT = 0;
  localparam int unsigned IRQ_RX_STOP_BIT   = 1;
  localparam int unsigned IRQ_TRIM_DONE_BIT = 2;
  localparam int unsigned IRQ_WIDTH         = 3;

  // command register fields, write-only pulses
  localparam int unsigned CMD_START_BIT = 0;
  localparam int unsigned CMD_STOP_BIT  = 1;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [7:0] CONTROL_RST  = 8'h00;
  localparam logic [7:0] RELOAD_RST   = 8'h00;
  localparam logic [2:0] IRQ_MASK_RST = 3'h0;

  ////////////////////////////////////////////////////////////////////////////
  // start_select and clock_select encodings
  localparam logic [1:0] START_NONE      = 2'h0;
  localparam logic [1:0] START_TX_END    = 2'h1;
  localparam logic [1:0] START_TRIM_NOUF = 2'h2;
  localparam logic [1:0] START_TRIM_UF   = 2'h3;

  localparam logic [1:0] CLK_CARRIER   = 2'h0;
  localparam logic [1:0] CLK_SLOW      = 2'h1;
  localparam logic [1:0] CLK_SIBLING_0 = 2'h2;
  localparam logic [1:0] CLK_SIBLING_1 = 2'h3;

  // carrier 13.56 MHz divided by 64 gives the 212 kHz count rate
  localparam int unsigned CARRIER_DIV = 64;

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ARM  = 3'b010,
    ST_RUN  = 3'b100
  } crt_state_e;

endpackage

`default_nettype wire

// ---- crt_tick_div.sv ----
/*
  tick divider: emits one pulse for every DIV input pulses.
  assumes tick_i is a one-cycle pulse synchronous to clk_i.
*/
`timescale 1ns/1ps
`default_nettype none

module crt_tick_div #(
  parameter int unsigned DIV = 64
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // ticks
  input  wire logic tick_i,
  output logic      tick_o
);

  localparam int unsigned CW = $clog2(DIV);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] cnt_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= '0;
    end else if (tick_i) begin
      cnt_reg <= (cnt_reg == LAST) ? '0 : cnt_reg + CW'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_o <= 1'b0;
    end else begin
      tick_o <= tick_i && (cnt_reg == LAST);
    end
  end

endmodule // crt_tick_div

`default_nettype wire

// ---- crt_timer.sv ----
/*
  cascadable 16-bit reload timer with a classic wishbone register slave,
  sticky interrupt status, mask and one level interrupt.
  assumes all event inputs are synchronous to clk_i, all but the edge-detected lfo_ref_i being one-cycle pulses, and
  that carrier_tick_i pulses once per carrier period.
*/
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// R1 - stop_on_receive set: halt counter once first four received bits arrive.
// R2 - stop_on_receive has no effect while start_select picks a trimming mode.
// R3 - start_select 00: no automatic start on any protocol event.
// R4 - start_select 01: counter starts when a transmission finishes.
// R5 - start_select 10: trimming, start/stop on reference rising edges, no underflow.
// R6 - start_select 11: trimming, start/stop on reference rising edges, underflow allowed.
// R7 - auto_restart set: at zero the counter reloads and keeps counting.
// R8 - auto_restart clear: counter decrements to zero and stops there.
// R9 - every underflow sets the timer_underflow_flag.
// R10 - clock_select 00: decrement at the carrier rate.
// R11 - clock_select 01: decrement at carrier divided down to 212 kHz.
// R12 - clock_select 10: decrement on each first_sibling_timer underflow.
// R13 - clock_select 11: decrement on each second_sibling_timer underflow.
// R14 - each start loads the counter from reload high and low bytes.
// R15 - reload writes do not disturb a running count; used at next start.
// R16 - live counter readable as high byte and low byte, read only.
// R17 - software must not read the counter bytes during reception.
// R18 - one-cycle underflow pulse offered for cascading into other timers.
// R19 - reserved control bits 6 and 2 read zero and ignore writes.
module crt_timer (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // wishbone slave
  input  wire logic       wb_cyc_i,
  input  wire logic       wb_stb_i,
  input  wire logic       wb_we_i,
  input  wire logic [7:0] wb_adr_i,
  input  wire logic [3:0] wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]     wb_dat_o,
  output logic            wb_ack_o,
  // protocol events
  input  wire logic       carrier_tick_i,
  input  wire logic       tx_done_i,
  input  wire logic       rx_first_bits_i,
  input  wire logic       lfo_ref_i,
  // cascade
  input  wire logic       sibling0_underflow_i,
  input  wire logic       sibling1_underflow_i,
  output logic            underflow_o,
  // status
  output logic            running_o,
  output logic            irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  logic [7:0]                    control_reg;
  logic [7:0]                    reload_high_reg;
  logic [7:0]                    reload_low_reg;
  logic [15:0]                   count_reg;
  logic [crt_pkg::IRQ_WIDTH-1:0] irq_status_reg;
  logic [crt_pkg::IRQ_WIDTH-1:0] irq_mask_reg;
  logic                          lfo_prev_reg;
  crt_pkg::crt_state_e           state_reg;

  logic        stop_on_receive;
  logic [1:0]  start_select;
  logic        auto_restart;
  logic [1:0]  clock_select;
  logic [15:0] reload_value;
  logic        trim_mode;
  logic        slow_tick;
  logic        count_tick;
  logic        lfo_rise;
  logic        bus_req;
  logic        bus_wr;
  logic [5:0]  bus_idx;
  logic        cmd_start;
  logic        cmd_stop;
  logic        rx_stop;
  logic        start_evt;
  logic        trim_start;
  logic        trim_stop;
  logic        at_zero;
  logic        uf_evt;
  logic        zero_halt;
  logic        load_now;
  logic [31:0] rd_data;
  logic [crt_pkg::IRQ_WIDTH-1:0] irq_set;

  assign stop_on_receive = control_reg[crt_pkg::CTL_STOP_RX_BIT];
  assign start_select    = control_reg[crt_pkg::CTL_START_HI:crt_pkg::CTL_START_LO];
  assign auto_restart    = control_reg[crt_pkg::CTL_AUTO_BIT];
  assign clock_select    = control_reg[crt_pkg::CTL_CLK_HI:crt_pkg::CTL_CLK_LO];
  assign reload_value    = {reload_high_reg, reload_low_reg}; // R14
  assign trim_mode       = start_select[1];

  ////////////////////////////////////////////////////////////////////////////
  // count rate selection
  crt_tick_div #(
    .DIV (crt_pkg::CARRIER_DIV)
  ) u_slow_div (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .tick_i (carrier_tick_i),
    .tick_o (slow_tick)
  );

  always_comb begin
    unique case (clock_select)
      crt_pkg::CLK_CARRIER:   count_tick = carrier_tick_i;       // R10
      crt_pkg::CLK_SLOW:      count_tick = slow_tick;            // R11
      crt_pkg::CLK_SIBLING_0: count_tick = sibling0_underflow_i; // R12
      crt_pkg::CLK_SIBLING_1: count_tick = sibling1_underflow_i; // R13
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus decode; writes land on the edge that sees ack high
  assign bus_req   = wb_cyc_i && wb_stb_i;
  assign bus_wr    = bus_req && wb_we_i && wb_ack_o && wb_sel_i[0];
  assign bus_idx   = wb_adr_i[7:2];
  assign cmd_start = bus_wr && (bus_idx == crt_pkg::IDX_COMMAND)
                     && wb_dat_i[crt_pkg::CMD_START_BIT];
  assign cmd_stop  = bus_wr && (bus_idx == crt_pkg::IDX_COMMAND)
                     && wb_dat_i[crt_pkg::CMD_STOP_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // events, in priority order: stop, receive stop, starts, counting
  assign lfo_rise   = lfo_ref_i && !lfo_prev_reg;
  assign rx_stop    = (state_reg == crt_pkg::ST_RUN) && stop_on_receive
                      && !trim_mode && rx_first_bits_i && !cmd_stop; // R1 R2
  assign start_evt  = !cmd_stop && !trim_mode && (cmd_start
                      || (start_select == crt_pkg::START_TX_END && tx_done_i)); // R3 R4
  assign trim_start = !cmd_stop && trim_mode && (state_reg == crt_pkg::ST_ARM)
                      && lfo_rise; // R5 R6
  assign trim_stop  = !cmd_stop && trim_mode && (state_reg == crt_pkg::ST_RUN)
                      && lfo_rise; // R5 R6
  assign at_zero    = (count_reg == 16'h0000);
  assign zero_halt  = (state_reg == crt_pkg::ST_RUN) && count_tick && at_zero
                      && !cmd_stop && !rx_stop && !start_evt && !trim_stop;
  // trimming without underflow parks at zero and raises no event
  assign uf_evt     = zero_halt && (start_select != crt_pkg::START_TRIM_NOUF); // R5 R6
  assign load_now   = start_evt || trim_start;

  ////////////////////////////////////////////////////////////////////////////
  // control and reload registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      control_reg <= crt_pkg::CONTROL_RST;
    end else if (bus_wr && bus_idx == crt_pkg::IDX_CONTROL) begin
      control_reg <= wb_dat_i[7:0] & crt_pkg::CTL_WRITE_MASK; // R19
    end
  end

  // reload bytes only feed the counter on a load, never mid-count
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reload_high_reg <= crt_pkg::RELOAD_RST;
      reload_low_reg  <= crt_pkg::RELOAD_RST;
    end else if (bus_wr) begin
      if (bus_idx == crt_pkg::IDX_RELOAD_HIGH) begin
        reload_high_reg <= wb_dat_i[7:0]; // R15
      end
      if (bus_idx == crt_pkg::IDX_RELOAD_LOW) begin
        reload_low_reg <= wb_dat_i[7:0]; // R15
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state machine
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= crt_pkg::ST_IDLE;
    end else if (cmd_stop || rx_stop || trim_stop) begin
      state_reg <= crt_pkg::ST_IDLE; // R1
    end else if (start_evt || trim_start) begin
      state_reg <= crt_pkg::ST_RUN;
    end else if (cmd_start && trim_mode) begin
      state_reg <= crt_pkg::ST_ARM;
    end else if (zero_halt && !(uf_evt && auto_restart)
                 && (start_select != crt_pkg::START_TRIM_NOUF)) begin
      // trimming without underflow parks at zero until the reference edge
      state_reg <= crt_pkg::ST_IDLE; // R8 R5
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // counter
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_reg <= 16'h0000;
    end else if (cmd_stop || rx_stop || trim_stop) begin
      count_reg <= count_reg;
    end else if (load_now) begin
      count_reg <= reload_value; // R14
    end else if (uf_evt && auto_restart) begin
      count_reg <= reload_value; // R7
    end else if ((state_reg == crt_pkg::ST_RUN) && count_tick && !at_zero) begin
      count_reg <= count_reg - 16'h0001; // R8
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lfo_prev_reg <= 1'b0;
    end else begin
      lfo_prev_reg <= lfo_ref_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      underflow_o <= 1'b0;
      running_o   <= 1'b0;
    end else begin
      underflow_o <= uf_evt; // R18
      running_o   <= (state_reg == crt_pkg::ST_RUN);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt status: set wins over write-one-to-clear
  always_comb begin
    irq_set = '0;
    irq_set[crt_pkg::IRQ_UNDERFLOW_BIT] = uf_evt; // R9
    irq_set[crt_pkg::IRQ_RX_STOP_BIT]   = rx_stop;
    irq_set[crt_pkg::IRQ_TRIM_DONE_BIT] = trim_stop;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_status_reg <= '0;
    end else if (bus_wr && bus_idx == crt_pkg::IDX_IRQ_STATUS) begin
      irq_status_reg <= (irq_status_reg & ~wb_dat_i[crt_pkg::IRQ_WIDTH-1:0]) | irq_set;
    end else begin
      irq_status_reg <= irq_status_reg | irq_set; // R9
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask_reg <= crt_pkg::IRQ_MASK_RST;
    end else if (bus_wr && bus_idx == crt_pkg::IDX_IRQ_MASK) begin
      irq_mask_reg <= wb_dat_i[crt_pkg::IRQ_WIDTH-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |((irq_status_reg | irq_set) & irq_mask_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux and acknowledge; unmapped reads return zero
  always_comb begin
    rd_data = 32'h0000_0000;
    unique case (bus_idx)
      crt_pkg::IDX_CONTROL:     rd_data[7:0] = control_reg; // R19
      crt_pkg::IDX_RELOAD_HIGH: rd_data[7:0] = reload_high_reg;
      crt_pkg::IDX_RELOAD_LOW:  rd_data[7:0] = reload_low_reg;
      crt_pkg::IDX_COUNT_HIGH:  rd_data[7:0] = count_reg[15:8]; // R16
      crt_pkg::IDX_COUNT_LOW:   rd_data[7:0] = count_reg[7:0]; // R16
      crt_pkg::IDX_IRQ_STATUS:  rd_data[crt_pkg::IRQ_WIDTH-1:0] = irq_status_reg;
      crt_pkg::IDX_IRQ_MASK:    rd_data[crt_pkg::IRQ_WIDTH-1:0] = irq_mask_reg;
      default:                  rd_data = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req && !wb_ack_o;
      if (bus_req && !wb_ack_o && !wb_we_i) begin
        wb_dat_o <= rd_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_tx_start;
    (state_reg == crt_pkg::ST_IDLE) && tx_done_i && !cmd_stop && !cmd_start;
  endsequence

  sequence s_trim_arm_edge;
    (state_reg == crt_pkg::ST_ARM) && lfo_rise && !cmd_stop && trim_mode;
  endsequence

  start_load_a: assert property (
    load_now |=> (count_reg == $past(reload_value)) && (state_reg == crt_pkg::ST_RUN)
  ) else $error("start did not load the reload value"); // R14

  tx_start_a: assert property (
    s_tx_start ##0 (start_select == crt_pkg::START_TX_END)
      |=> (state_reg == crt_pkg::ST_RUN) ##1 running_o
  ) else $error("end of transmission did not start the timer"); // R4

  no_auto_start_a: assert property (
    s_tx_start ##0 (start_select == crt_pkg::START_NONE)
      |=> (state_reg == crt_pkg::ST_IDLE)
  ) else $error("timer started with automatic start off"); // R3

  trim_start_a: assert property (
    s_trim_arm_edge |=> (state_reg == crt_pkg::ST_RUN) && (count_reg == $past(reload_value))
  ) else $error("trimming did not start on reference edge"); // R5

  trim_no_uf_a: assert property (
    zero_halt && (start_select == crt_pkg::START_TRIM_NOUF)
      |=> !underflow_o && (state_reg == crt_pkg::ST_RUN) && (count_reg == 16'h0000)
  ) else $error("trimming without underflow raised an underflow"); // R5

  trim_uf_a: assert property (
    zero_halt && (start_select == crt_pkg::START_TRIM_UF) |=> underflow_o
  ) else $error("trimming with underflow lost the underflow"); // R6

  auto_reload_a: assert property (
    uf_evt && auto_restart
      |=> (count_reg == $past(reload_value)) && (state_reg == crt_pkg::ST_RUN)
  ) else $error("auto restart did not reload"); // R7

  stop_zero_a: assert property (
    uf_evt && !auto_restart
      |=> (state_reg == crt_pkg::ST_IDLE) && (count_reg == 16'h0000)
  ) else $error("timer did not stop at zero"); // R8

  flag_set_a: assert property (
    uf_evt |=> irq_status_reg[crt_pkg::IRQ_UNDERFLOW_BIT] && underflow_o
  ) else $error("underflow flag or pulse missing"); // R9

  uf_pulse_a: assert property (
    !uf_evt |=> !underflow_o
  ) else $error("underflow pulse without an underflow"); // R18

  decrement_a: assert property (
    (state_reg == crt_pkg::ST_RUN) && count_tick && !at_zero && !load_now
      && !cmd_stop && !rx_stop && !trim_stop
      |=> count_reg == $past(count_reg) - 16'h0001
  ) else $error("counter did not decrement on the selected tick"); // R10

  slow_rate_a: assert property (
    (clock_select == crt_pkg::CLK_SLOW) && !slow_tick && !load_now && !uf_evt
      |=> $stable(count_reg)
  ) else $error("slow rate counted without a divided tick"); // R11

  sibling_rate_a: assert property (
    (clock_select == crt_pkg::CLK_SIBLING_0) && (state_reg == crt_pkg::ST_RUN)
      && !sibling0_underflow_i && !load_now |=> $stable(count_reg)
  ) else $error("cascade counted without a sibling underflow"); // R12

  rx_stop_a: assert property (
    rx_stop |=> (state_reg == crt_pkg::ST_IDLE) ##1 !running_o
  ) else $error("receive stop did not halt the timer"); // R1

  trim_ignore_rx_a: assert property (
    trim_mode && (state_reg == crt_pkg::ST_RUN) && rx_first_bits_i && !lfo_rise
      && !cmd_stop && !at_zero |=> (state_reg == crt_pkg::ST_RUN)
  ) else $error("receive stop acted during trimming"); // R2

  reload_hold_a: assert property (
    (state_reg == crt_pkg::ST_RUN) && bus_wr && !count_tick && !load_now
      && (bus_idx == crt_pkg::IDX_RELOAD_LOW) |=> $stable(count_reg)
  ) else $error("reload write disturbed the count"); // R15

  ctl_reserved_a: assert property (
    !control_reg[6] && !control_reg[2]
  ) else $error("reserved control bit is set"); // R19

endmodule // crt_timer

`default_nettype wire

// ---- tb_cascadable_reload_timer.sv ----
/*
  self-checking bench for crt_timer: register access over classic wishbone,
  start, stop, reload, clock selection, trimming modes and the interrupt.
  assumes the crt_pkg constants and the registered one-cycle ack of the slave.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_cascadable_reload_timer;

  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc   = 1'b0;
  logic        stb   = 1'b0;
  logic        we    = 1'b0;
  logic [7:0]  adr   = 8'h00;
  logic [3:0]  sel   = 4'hF;
  logic [31:0] dat   = 32'h00000000;
  logic [31:0] rdat;
  logic        ack;
  logic        car   = 1'b0;
  logic        tx    = 1'b0;
  logic        rx    = 1'b0;
  logic        low_frequency_oscillator   = 1'b0;
  logic        s0    = 1'b0;
  logic        s1    = 1'b0;
  logic        uf;
  logic        run;
  logic        irq;
  logic [7:0]  n_uf  = 8'h00;
  logic [7:0]  n0;
  int          errors  = 0;
  int          n_tests = 0;

  crt_timer i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .carrier_tick_i(car), .tx_done_i(tx), .rx_first_bits_i(rx), .lfo_ref_i(low_frequency_oscillator),
    .sibling0_underflow_i(s0), .sibling1_underflow_i(s1), .underflow_o(uf),
    .running_o(run), .irq_o(irq)
  );

  always #20 clk_i = ~clk_i;

  // counts cycles with the cascade pulse high
  always @(posedge clk_i) begin
    if (uf === 1'b1) n_uf <= n_uf + 8'h01;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [5:0] idx, input logic [7:0] d,
                    output logic [7:0] q);
    int k;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= {idx, 2'b00};
    dat <= {24'h000000, d};
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 16);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    if (k >= 16) chk8({7'h00, ack}, 8'h01);
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, idx, d, q);
  endtask

  task automatic rd(input logic [5:0] idx, input logic [7:0] exp);
    logic [7:0] q;
    wb(1'b0, idx, 8'h00, q);
    chk8(q, exp);
  endtask

  // holds {carrier, sibling0, sibling1, tx_done, rx_bits} for n cycles
  task automatic drv(input logic [4:0] v, input int n);
    @(posedge clk_i);
    {car, s0, s1, tx, rx} <= v;
    repeat (n) @(posedge clk_i);
    {car, s0, s1, tx, rx} <= 5'h00;
  endtask

  task automatic lfo_edge();
    @(posedge clk_i);
    low_frequency_oscillator <= 1'b1;
    repeat (3) @(posedge clk_i);
    low_frequency_oscillator <= 1'b0;
  endtask

  task automatic flag(input logic which, input logic exp);
    repeat (3) @(posedge clk_i);
    chk8({7'h00, which ? irq : run}, {7'h00, exp});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    for (int i = 0; i < 5; i++) rd(crt_pkg::IDX_CONTROL + 6'(i), 8'h00);
    rd(6'h3F, 8'h00);
    wr(crt_pkg::IDX_CONTROL, 8'hFF);
    rd(crt_pkg::IDX_CONTROL, 8'hBB);
    wr(crt_pkg::IDX_COUNT_HIGH, 8'hFF);
    rd(crt_pkg::IDX_COUNT_HIGH, 8'h00);
    wr(6'h3F, 8'h77);
    rd(6'h3F, 8'h00);
  endtask

  task automatic t_load();
    wr(crt_pkg::IDX_CONTROL, 8'h00);
    wr(crt_pkg::IDX_RELOAD_HIGH, 8'h01);
    wr(crt_pkg::IDX_RELOAD_LOW, 8'h02);
    wr(crt_pkg::IDX_COMMAND, 8'h01);
    rd(crt_pkg::IDX_COUNT_HIGH, 8'h01);
    wr(crt_pkg::IDX_RELOAD_HIGH, 8'h00);
    rd(crt_pkg::IDX_COUNT_LOW, 8'h02);
    drv(5'h10, 2);
    rd(crt_pkg::IDX_COUNT_LOW, 8'h00);
    rd(crt_pkg::IDX_COUNT_HIGH, 8'h01);
    wr(crt_pkg::IDX_COMMAND, 8'h02);
    wr(crt_pkg::IDX_COMMAND, 8'h01);
    rd(crt_pkg::IDX_COUNT_HIGH, 8'h00);
  endtask

  task automatic t_underflow();
    wr(crt_pkg::IDX_IRQ_MASK, 8'h01);
    n0 = n_uf;
    drv(5'h10, 3);
    flag(1'b0, 1'b0);
    chk8(n_uf, n0 + 8'h01);
    drv(5'h10, 2);
    rd(crt_pkg::IDX_COUNT_LOW, 8'h00);
    chk8(n_uf, n0 + 8'h01);
    rd(crt_pkg::IDX_IRQ_STATUS, 8'h01);
    flag(1'b1, 1'b1);
    wr(crt_pkg::IDX_IRQ_MASK, 8'h00);
    flag(1'b1, 1'b0);
    wr(crt_pkg::IDX_IRQ_MASK, 8'h01);
    flag(1'b1, 1'b1);
    wr(crt_pkg::IDX_IRQ_STATUS, 8'h01);
    flag(1'b1, 1'b0);
  endtask

  task automatic t_auto();
    wr(crt_pkg::IDX_CONTROL, 8'h08);
    wr(crt_pkg::IDX_COMMAND, 8'h01);
    n0 = n_uf;
    drv(5'h10, 3);
    rd(crt_pkg::IDX_COUNT_LOW, 8'h02);
    flag(1'b0, 1'b1);
    chk8(n_uf, n0 + 8'h01);
    wr(crt_pkg::IDX_COMMAND, 8'h02);
  endtask

  task automatic t_clk();
    wr(crt_pkg::IDX_CONTROL, 8'h01);
    wr(crt_pkg::IDX_RELOAD_LOW, 8'h05);
    wr(crt_pkg::IDX_COMMAND, 8'h01);
    drv(5'h10, 128);
    rd(crt_pkg::IDX_COUNT_LOW, 8'h03);
    wr(crt_pkg::IDX_CONTROL, 8'h02);
    wr(crt_pkg::IDX_COMMAND, 8'h01);
    drv(5'h08, 2);
    drv(5'h04, 3);
    drv(5'h10, 4);
    rd(crt_pkg::IDX_COUNT_LOW, 8'h03);
    wr(crt_pkg::IDX_CONTROL, 8'h03);
    wr(crt_pkg::IDX_COMMAND, 8'h01);
    drv(5'h08, 2);
    drv(5'h04, 1);
    rd(crt_pkg::IDX_COUNT_LOW, 8'h04);
    wr(crt_pkg::IDX_COMMAND, 8'h02);
  endtask

  task automatic t_start();
    wr(crt_pkg::IDX_CONTROL, 8'h00);
    drv(5'h02, 1);
    flag(1'b0, 1'b0);
    wr(crt_pkg::IDX_CONTROL, 8'h10);
    drv(5'h02, 1);
    flag(1'b0, 1'b1);
    drv(5'h01, 1);
    flag(1'b0, 1'b1);
    wr(crt_pkg::IDX_CONTROL, 8'h90);
    drv(5'h01, 1);
    flag(1'b0, 1'b0);
  endtask

  task automatic t_trim();
    wr(crt_pkg::IDX_IRQ_STATUS, 8'h07);
    wr(crt_pkg::IDX_CONTROL, 8'hA0);
    wr(crt_pkg::IDX_RELOAD_LOW, 8'h01);
    wr(crt_pkg::IDX_COMMAND, 8'h01);
    lfo_edge();
    flag(1'b0, 1'b1);
    drv(5'h01, 1);
    flag(1'b0, 1'b1);
    n0 = n_uf;
    drv(5'h10, 4);
    rd(crt_pkg::IDX_COUNT_LOW, 8'h00);
    chk8(n_uf, n0);
    lfo_edge();
    flag(1'b0, 1'b0);
    rd(crt_pkg::IDX_IRQ_STATUS, 8'h04);
    wr(crt_pkg::IDX_CONTROL, 8'h30);
    wr(crt_pkg::IDX_COMMAND, 8'h01);
    lfo_edge();
    drv(5'h10, 3);
    flag(1'b0, 1'b0);
    chk8(n_uf, n0 + 8'h01);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_load();
    t_underflow();
    t_auto();
    t_clk();
    t_start();
    t_trim();
    summarize();
  end

  // about 400 cycles expected; cut off well beyond
  initial begin
    #400000;
    errors++;
    summarize();
  end

endmodule // tb_cascadable_reload_timer

`default_nettype wire
